// [include/pcp_params.svh]
`ifndef PCP_PARAMS_SVH
`define PCP_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define PCP_CLK_KHZ       125000
`define PCP_DB_SHORT_MS   32
`define PCP_DB_MID_MS     125
`define PCP_DB_LONG_MS    750
`define PCP_SEC_MS        1000
`define PCP_DISCHARGE_US  30
`define PCP_SLOT_CYC_DEF  250
`define PCP_CNT_W         27
`define PCP_SEC_MAX       5'h1f
`define PCP_TRESET_BASE_S 5'h02

// ----------------------------------------
// Register map
// ----------------------------------------
`define PCP_ADR_CTRL      8'h00
`define PCP_ADR_STAT      8'h04
`define PCP_ADR_IRQ       8'h08
`define PCP_CTRL_RSTEN    0
`define PCP_CTRL_DBNC     1
`define PCP_CTRL_DELAY    3
`define PCP_CTRL_SINV     5
`define PCP_STAT_SENSE    0
`define PCP_STAT_STBY     1
`define PCP_STAT_CPUREL   2
`define PCP_STAT_SUPPLY   3
`define PCP_STAT_STATE    4
`define PCP_IRQ_PUSH      0
`define PCP_IRQ_REL       1
`define PCP_IRQ_HOLD      2
`define PCP_IRQ_W         7
`define PCP_HOLD_N        5

`endif

// [include/pcp_pkg.sv]
`include "pcp_params.svh"
package pcp_pkg;

  typedef enum logic [2:0] {st_off, st_pwrup, st_on, st_pwrdn, st_discharge} pcp_state_t;

  typedef struct packed {
    logic [1:0]            pin_sync;
    logic [1:0]            stby_sync;
    pcp_state_t            state;
    logic                  otp_load;
    logic                  rst_en;
    logic [1:0]            dbnc_sel;
    logic [1:0]            delay_sel;
    logic                  stby_inv;
    logic [`PCP_IRQ_W-1:0] irq;
    logic [`PCP_CNT_W-1:0] sub_cnt;
    logic [4:0]            sec_cnt;
    logic [7:0]            slot;
    logic [15:0]           slot_tmr;
    logic                  reset_pending;
    logic                  cpu_rst_n;
    logic                  cpu_rst_drv;
    logic                  standby;
    logic                  supplies_on;
    logic                  ack;
    logic [31:0]           dat;
  } pcp_top_t;

endpackage

// [hdl/pcp_debounce.sv]
`timescale 1ns/1ps
`include "pcp_params.svh"
module pcp_debounce #(
  parameter int unsigned CNT_W = `PCP_CNT_W
) (
  // Clock and control
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // Level and thresholds
  input  wire logic             level_i,
  input  wire logic [CNT_W-1:0] fall_cyc_i,
  input  wire logic [CNT_W-1:0] rise_cyc_i,
  // Debounced result
  output logic                  level_o,
  output logic                  fall_o,
  output logic                  rise_o
);

  typedef struct packed {
    logic             lvl;
    logic             fall;
    logic             rise;
    logic [CNT_W-1:0] cnt;
  } pcp_db_t;

  localparam pcp_db_t RST_VAL = '{lvl: 1'b1, fall: 1'b0, rise: 1'b0, cnt: '0};

  pcp_db_t st;
  pcp_db_t next_st;

  always_comb
  begin
    logic [CNT_W-1:0] need;
    need = level_i ? rise_cyc_i : fall_cyc_i;
    next_st = st;
    next_st.fall = 1'b0;
    next_st.rise = 1'b0;
    if (level_i == st.lvl)
    begin
      next_st.cnt = '0;
    end
    else if (st.cnt >= need - 1'b1)
    begin
      next_st.lvl  = level_i;
      next_st.cnt  = '0;
      next_st.fall = !level_i;
      next_st.rise = level_i;
    end
    else
    begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st <= RST_VAL;
    else if (ce_i)
      st <= next_st;
  end

  assign level_o = st.lvl;
  assign fall_o  = st.fall;
  assign rise_o  = st.rise;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_db_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && level_i == st.lvl) |=> st.cnt == '0)
    else $error("debounce counter not restarted");

  chk_db_edge_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(st.lvl) |-> (st.fall || st.rise))
    else $error("debounced level changed without pulse");

endmodule

// [hdl/pcp_top.sv]
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "pcp_params.svh"
module pcp_top #(
  parameter int unsigned DB_SHORT_CYC = `PCP_DB_SHORT_MS * `PCP_CLK_KHZ,
  parameter int unsigned DB_MID_CYC   = `PCP_DB_MID_MS * `PCP_CLK_KHZ,
  parameter int unsigned DB_LONG_CYC  = `PCP_DB_LONG_MS * `PCP_CLK_KHZ,
  parameter int unsigned SEC_CYC      = `PCP_SEC_MS * `PCP_CLK_KHZ,
  parameter int unsigned SLOT_CYC     = `PCP_SLOT_CYC_DEF
) (
  // Clock and control
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // OTP defaults
  input  wire logic        otp_button_edge_select_i,
  input  wire logic [1:0]  otp_button_debounce_default_i,
  input  wire logic [1:0]  otp_long_press_delay_default_i,
  input  wire logic [7:0]  otp_cpu_reset_release_slot_i,
  // Pins
  input  wire logic        power_on_input_i,
  input  wire logic        standby_i,
  output logic             processor_reset_n_o,
  output logic             processor_reset_oe_o,
  // Device state
  output logic             standby_mode_o,
  output logic             supplies_on_o
);

  localparam int unsigned DIS_CYC = (`PCP_DISCHARGE_US * `PCP_CLK_KHZ + 999) / 1000;
  localparam logic [4:0] HOLD_S [`PCP_HOLD_N] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h08};

  localparam pcp_pkg::pcp_top_t RST_VAL = '{
    pin_sync: 2'h3, stby_sync: 2'h0, state: pcp_pkg::st_off, otp_load: 1'b1,
    rst_en: 1'b0, dbnc_sel: 2'h0, delay_sel: 2'h0, stby_inv: 1'b0,
    irq: '0, sub_cnt: '0, sec_cnt: 5'h00, slot: 8'h00, slot_tmr: 16'h0000,
    reset_pending: 1'b0, cpu_rst_n: 1'b0, cpu_rst_drv: 1'b1, standby: 1'b0,
    supplies_on: 1'b0, ack: 1'b0, dat: 32'h0000_0000};

  pcp_pkg::pcp_top_t st;
  pcp_pkg::pcp_top_t next_st;

  logic db_level;
  logic db_fall;
  logic db_rise;

  // ----------------------------------------
  // Debounce decode
  // ----------------------------------------
  function automatic logic [`PCP_CNT_W-1:0] fall_need(input logic [1:0] sel);
    case (sel)
      2'b10:   fall_need = `PCP_CNT_W'(DB_MID_CYC);
      2'b11:   fall_need = `PCP_CNT_W'(DB_LONG_CYC);
      default: fall_need = `PCP_CNT_W'(DB_SHORT_CYC);
    endcase
  endfunction

  pcp_debounce #(
    .CNT_W (`PCP_CNT_W)
  ) u_debounce (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .level_i    (st.pin_sync[1]),
    .fall_cyc_i (fall_need(st.dbnc_sel)),
    .rise_cyc_i (`PCP_CNT_W'(DB_SHORT_CYC)),
    .level_o    (db_level),
    .fall_o     (db_fall),
    .rise_o     (db_rise)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic       bus_req;
  logic       sec_tick;
  logic       lp_hit;
  logic [4:0] sec_next;
  logic [31:0] rd;

  always_comb
  begin
    next_st = st;
    next_st.pin_sync  = {st.pin_sync[0], power_on_input_i};
    next_st.stby_sync = {st.stby_sync[0], standby_i};
    next_st.ack = 1'b0;

    // Register read mux
    rd = 32'h0000_0000;
    case (wb_adr_i)
      `PCP_ADR_CTRL:
      begin
        rd[`PCP_CTRL_RSTEN]     = st.rst_en;
        rd[`PCP_CTRL_DBNC +: 2]  = st.dbnc_sel;
        rd[`PCP_CTRL_DELAY +: 2] = st.delay_sel;
        rd[`PCP_CTRL_SINV]      = st.stby_inv;
      end
      `PCP_ADR_STAT:
      begin
        rd[`PCP_STAT_SENSE]      = st.pin_sync[1];
        rd[`PCP_STAT_STBY]       = st.standby;
        rd[`PCP_STAT_CPUREL]     = st.cpu_rst_n;
        rd[`PCP_STAT_SUPPLY]     = st.supplies_on;
        rd[`PCP_STAT_STATE +: 3] = st.state;
      end
      `PCP_ADR_IRQ: rd[`PCP_IRQ_W-1:0] = st.irq;
      default:      rd = 32'h0000_0000;
    endcase

    // Bus access, one ack per request
    bus_req = wb_cyc_i && wb_stb_i && !st.ack;
    if (bus_req)
    begin
      next_st.ack = 1'b1;
      next_st.dat = rd;
      if (wb_we_i && wb_sel_i[0])
      begin
        case (wb_adr_i)
          `PCP_ADR_CTRL:
          begin
            next_st.rst_en    = wb_dat_i[`PCP_CTRL_RSTEN];
            next_st.dbnc_sel  = wb_dat_i[`PCP_CTRL_DBNC +: 2];
            next_st.delay_sel = wb_dat_i[`PCP_CTRL_DELAY +: 2];
            next_st.stby_inv  = wb_dat_i[`PCP_CTRL_SINV];
          end
          `PCP_ADR_IRQ: next_st.irq = st.irq & ~wb_dat_i[`PCP_IRQ_W-1:0];
          default: ;
        endcase
      end
    end

    // OTP defaults load after reset and device reset
    if (st.otp_load)
    begin
      next_st.dbnc_sel  = otp_button_debounce_default_i;
      next_st.delay_sel = otp_long_press_delay_default_i;
      next_st.rst_en    = 1'b0;
      next_st.stby_inv  = 1'b0;
      next_st.otp_load  = 1'b0;
    end

    // Hold timers, run while debounced low; sub_cnt also counts while high in level mode in st_off
    sec_tick = 1'b0;
    sec_next = st.sec_cnt + 5'h01;
    if (db_level)
    begin
      next_st.sub_cnt = (!otp_button_edge_select_i && st.state == pcp_pkg::st_off
                         && st.pin_sync[1]) ? st.sub_cnt + 1'b1 : '0;
      next_st.sec_cnt = 5'h00;
    end
    else if (st.sub_cnt == `PCP_CNT_W'(SEC_CYC - 1))
    begin
      next_st.sub_cnt = '0;
      if (st.sec_cnt != `PCP_SEC_MAX)
      begin
        next_st.sec_cnt = sec_next;
        sec_tick = 1'b1;
      end
    end
    else
    begin
      next_st.sub_cnt = st.sub_cnt + 1'b1;
    end
    for (int i = 0; i < `PCP_HOLD_N; i++)
    begin
      if (sec_tick && sec_next == HOLD_S[i])
        next_st.irq[`PCP_IRQ_HOLD + i] = 1'b1;
    end
    lp_hit = sec_tick && sec_next == (`PCP_TRESET_BASE_S << st.delay_sel);

    // Press and release latches, set wins over clear
    if (st.state == pcp_pkg::st_on && db_fall)
      next_st.irq[`PCP_IRQ_PUSH] = 1'b1;
    if (st.state == pcp_pkg::st_on && db_rise)
      next_st.irq[`PCP_IRQ_REL] = 1'b1;

    // Power sequencer
    next_st.standby = 1'b0;
    case (st.state)
      pcp_pkg::st_off:
      begin
        next_st.supplies_on = 1'b0;
        if (otp_button_edge_select_i ? db_fall
            : (db_level && st.sub_cnt >= `PCP_CNT_W'(DB_SHORT_CYC - 1)))
        begin
          next_st.state    = pcp_pkg::st_pwrup;
          next_st.slot     = 8'h00;
          next_st.slot_tmr = 16'h0000;
        end
      end
      pcp_pkg::st_pwrup:
      begin
        next_st.supplies_on = 1'b1;
        if ((!otp_button_edge_select_i && !db_level) || lp_hit)
        begin
          next_st.state         = pcp_pkg::st_pwrdn;
          next_st.reset_pending = lp_hit && st.rst_en;
          next_st.slot          = 8'hff;
          next_st.slot_tmr      = 16'h0000;
        end
        else if (st.slot == otp_cpu_reset_release_slot_i)
        begin
          next_st.cpu_rst_n   = 1'b1;
          next_st.cpu_rst_drv = 1'b0;
          next_st.state       = pcp_pkg::st_on;
        end
        else if (st.slot_tmr == 16'(SLOT_CYC - 1))
        begin
          next_st.slot_tmr = 16'h0000;
          next_st.slot     = st.slot + 8'h01;
        end
        else
        begin
          next_st.slot_tmr = st.slot_tmr + 16'h0001;
        end
      end
      pcp_pkg::st_on:
      begin
        next_st.standby = st.stby_sync[1] ^ st.stby_inv;
        if ((!otp_button_edge_select_i && !db_level) || lp_hit)
        begin
          next_st.state         = pcp_pkg::st_pwrdn;
          next_st.reset_pending = lp_hit && st.rst_en;
          next_st.slot          = 8'hff;
          next_st.slot_tmr      = 16'h0000;
          next_st.standby       = 1'b0;
        end
      end
      pcp_pkg::st_pwrdn:
      begin
        if (st.slot == otp_cpu_reset_release_slot_i)
        begin
          next_st.cpu_rst_n   = 1'b0;
          next_st.cpu_rst_drv = 1'b1;
        end
        if (st.slot_tmr == 16'(SLOT_CYC - 1))
        begin
          next_st.slot_tmr = 16'h0000;
          if (st.slot == 8'h00)
          begin
            next_st.supplies_on = 1'b0;
            next_st.state = st.reset_pending ? pcp_pkg::st_discharge : pcp_pkg::st_off;
          end
          else
          begin
            next_st.slot = st.slot - 8'h01;
          end
        end
        else
        begin
          next_st.slot_tmr = st.slot_tmr + 16'h0001;
        end
      end
      pcp_pkg::st_discharge:
      begin
        if (st.slot_tmr == 16'(DIS_CYC - 1))
        begin
          next_st.state         = pcp_pkg::st_pwrup;
          next_st.otp_load      = 1'b1;
          next_st.reset_pending = 1'b0;
          next_st.slot          = 8'h00;
          next_st.slot_tmr      = 16'h0000;
        end
        else
        begin
          next_st.slot_tmr = st.slot_tmr + 16'h0001;
        end
      end
      default: next_st.state = pcp_pkg::st_off;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st <= RST_VAL;
    else if (ce_i)
      st <= next_st;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_dat_o             = st.dat;
  assign wb_ack_o             = st.ack;
  assign processor_reset_n_o  = st.cpu_rst_n;
  assign processor_reset_oe_o = st.cpu_rst_drv;
  assign standby_mode_o       = st.standby;
  assign supplies_on_o        = st.supplies_on;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  sequence s_long_press_on;
    st.state == pcp_pkg::st_on && lp_hit;
  endsequence

  sequence s_enter_pwrdn;
    st.state == pcp_pkg::st_pwrdn && st.slot == 8'hff;
  endsequence

  chk_level_start: assert property (
    (!otp_button_edge_select_i && st.state == pcp_pkg::st_off && db_level
     && st.sub_cnt >= `PCP_CNT_W'(DB_SHORT_CYC - 1))
    |=> st.state == pcp_pkg::st_pwrup)
    else $error("level mode did not start power-up");

  chk_level_hold_off: assert property (
    (!otp_button_edge_select_i && st.state == pcp_pkg::st_off && !db_level)
    |=> st.state == pcp_pkg::st_off)
    else $error("level mode left off while input low");

  chk_edge_start: assert property (
    (otp_button_edge_select_i && st.state == pcp_pkg::st_off && db_fall)
    |=> st.state == pcp_pkg::st_pwrup ##1 st.supplies_on)
    else $error("button press did not start power-up");

  chk_sense_mirror: assert property (
    (bus_req && !wb_we_i && wb_adr_i == `PCP_ADR_STAT)
    |=> wb_ack_o && wb_dat_o[`PCP_STAT_SENSE] == $past(st.pin_sync[1]))
    else $error("sense bit does not mirror input");

  chk_dbnc_long: assert property (
    st.dbnc_sel == 2'b11 |-> fall_need(st.dbnc_sel) == `PCP_CNT_W'(DB_LONG_CYC))
    else $error("debounce code decode wrong");

  chk_otp_load: assert property (
    st.otp_load |=> st.dbnc_sel == $past(otp_button_debounce_default_i)
                 && st.delay_sel == $past(otp_long_press_delay_default_i))
    else $error("otp defaults not loaded");

  chk_push_latch: assert property (
    (st.state == pcp_pkg::st_on && db_fall) |=> st.irq[`PCP_IRQ_PUSH] [*2])
    else $error("pushed latch not set");

  chk_rel_latch: assert property (
    (st.state == pcp_pkg::st_on && db_rise) |=> st.irq[`PCP_IRQ_REL])
    else $error("released latch not set");

  chk_hold_1s: assert property (
    (sec_tick && sec_next == 5'h01) |=> st.irq[`PCP_IRQ_HOLD])
    else $error("one second hold latch not set");

  chk_long_reset: assert property (
    (s_long_press_on and st.rst_en) |=> s_enter_pwrdn and st.reset_pending)
    else $error("long press did not start device reset");

  chk_long_off: assert property (
    (s_long_press_on and !st.rst_en) |=> s_enter_pwrdn and !st.reset_pending)
    else $error("long press did not start turn-off");

  chk_discharge_len: assert property (
    (st.state == pcp_pkg::st_discharge ##1 st.state != pcp_pkg::st_discharge)
    |-> $past(st.slot_tmr) == 16'(DIS_CYC - 1) && st.otp_load)
    else $error("discharge wait wrong");

  chk_standby_xor: assert property (
    (st.state == pcp_pkg::st_on && !lp_hit && db_level)
    |=> standby_mode_o == ($past(st.stby_sync[1]) ^ $past(st.stby_inv)))
    else $error("standby not pin xor invert");

  chk_rst_open_drain: assert property (
    processor_reset_oe_o == !processor_reset_n_o)
    else $error("reset drive enable mismatch");

  chk_on_released: assert property (
    st.state == pcp_pkg::st_on |-> processor_reset_n_o)
    else $error("processor reset asserted in on state");

  chk_irq_clear: assert property (
    (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `PCP_ADR_IRQ
     && wb_dat_i[`PCP_IRQ_REL] && !(st.state == pcp_pkg::st_on && db_rise))
    |=> !st.irq[`PCP_IRQ_REL])
    else $error("write one did not clear latch");

  chk_hold_restart: assert property (
    db_level |=> st.sec_cnt == 5'h00)
    else $error("hold timer not reset on release");

endmodule

// [verification/pcp_button_model.sv]
`timescale 1ns/1ps
module pcp_button_model (
  // Clock
  input  wire logic clk_i,
  // Bench commands
  input  wire logic press_i,
  input  wire logic bounce_i,
  // Processor reset pin enable
  input  wire logic reset_oe_i,
  // Wire levels
  output logic      button_o,
  output logic      cpu_reset_wire_o
);
  initial button_o = 1'h1;

  // ----------------------------------------
  // Button contact, pull-up when open
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (bounce_i)
      button_o <= !button_o;
    else
      button_o <= !press_i;
  end

  // ----------------------------------------
  // Open-drain reset wire with pull-up
  // ----------------------------------------
  assign cpu_reset_wire_o = reset_oe_i ? 1'h0 : 1'h1;
endmodule

// [verification/test_pcp_top.sv]
`timescale 1ns/1ps
`include "pcp_params.svh"
module test_pcp_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [7:0] AC = `PCP_ADR_CTRL;
  localparam logic [7:0] AS = `PCP_ADR_STAT;
  localparam logic [7:0] AI = `PCP_ADR_IRQ;
  logic        clk_i     = 1'h0;
  logic        rst_i     = 1'h1;
  logic        wb_cyc_i  = 1'h0;
  logic        wb_stb_i  = 1'h0;
  logic        wb_we_i   = 1'h0;
  logic [7:0]  wb_adr_i  = 8'h00;
  logic [31:0] wb_dat_i  = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        edge_sel  = 1'h1;
  logic        press     = 1'h0;
  logic        bounce    = 1'h0;
  logic        standby_i = 1'h0;
  logic        ce        = 1'h1;
  logic [3:0]  sel       = 4'hf;
  logic [3:0]  wb_sel_i  = 4'h0;
  logic [1:0]  otp_db    = 2'h2;
  logic [1:0]  otp_dly   = 2'h0;
  logic [7:0]  otp_slot  = 8'h03;
  logic        pin;
  logic        rst_n;
  logic        rst_oe;
  logic        wire_rst;
  logic        stby;
  logic        sup;
  logic [31:0] q;
  int          cnt;
  int          error_cnt = 0;
  int          tests_run = 0;

  always #4 clk_i = ~clk_i;

  // ----------------------------------------
  // Device and partner
  // ----------------------------------------
  pcp_top #(.DB_SHORT_CYC(8), .DB_MID_CYC(12), .DB_LONG_CYC(20), .SEC_CYC(50), .SLOT_CYC(4))
  i_pcp_top (
    .clk_i                          (clk_i),
    .rst_i                          (rst_i),
    .ce_i                           (ce),
    .wb_cyc_i                       (wb_cyc_i),
    .wb_stb_i                       (wb_stb_i),
    .wb_we_i                        (wb_we_i),
    .wb_adr_i                       (wb_adr_i),
    .wb_sel_i                       (wb_sel_i),
    .wb_dat_i                       (wb_dat_i),
    .wb_dat_o                       (wb_dat_o),
    .wb_ack_o                       (wb_ack_o),
    .otp_button_edge_select_i       (edge_sel),
    .otp_button_debounce_default_i  (otp_db),
    .otp_long_press_delay_default_i (otp_dly),
    .otp_cpu_reset_release_slot_i   (otp_slot),
    .power_on_input_i               (pin),
    .standby_i                      (standby_i),
    .processor_reset_n_o            (rst_n),
    .processor_reset_oe_o           (rst_oe),
    .standby_mode_o                 (stby),
    .supplies_on_o                  (sup)
  );

  pcp_button_model i_pcp_button_model (
    .clk_i            (clk_i),
    .press_i          (press),
    .bounce_i         (bounce),
    .reset_oe_i       (rst_oe),
    .button_o         (pin),
    .cpu_reset_wire_o (wire_rst)
  );

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_sel_i <= sel;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
    end
    while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic till(input logic s, input logic v, input int lim);
    cnt = 0;
    while (((s ? sup : rst_n) !== v) && cnt < lim)
    begin
      @(posedge clk_i);
      cnt++;
    end
    chk(32'(cnt < lim), 32'h1);
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    wt(5);
    rst_i <= 1'h0;
    wt(2);
    chk(32'(rst_oe), 32'h1);
    chk(32'(wire_rst), 32'h0);
    chk(32'(sup), 32'h0);
    rd(AC, 32'h04);
    wb(1'h1, AS, 32'h7f);
    rd(AS, 32'h01);
    wb(1'h1, 8'h0c, 32'h7f);
    rd(8'h0c, 32'h0);
    $display("reset test done");
    // Frozen clock enable, then byte lane off
    ce <= 1'h0;
    press <= 1'h1;
    wt(30);
    press <= 1'h0;
    wt(4);
    ce <= 1'h1;
    sel <= 4'he;
    wb(1'h1, AC, 32'h3f);
    sel <= 4'hf;
    wt(20);
    rd(AS, 32'h01);
    rd(AC, 32'h04);
    $display("enable test done");
    // Short press and bounce ignored
    press <= 1'h1;
    wt(9);
    press <= 1'h0;
    wt(30);
    rd(AS, 32'h01);
    bounce <= 1'h1;
    wt(40);
    bounce <= 1'h0;
    wt(30);
    rd(AS, 32'h01);
    $display("debounce test done");
    // Power-up by press, hold latches
    wb(1'h1, AC, 32'h1c);
    rd(AC, 32'h1c);
    press <= 1'h1;
    till(1'h0, 1'h1, 100);
    chk(32'(wire_rst), 32'h1);
    rd(AS, 32'h2c);
    wt(220);
    rd(AI, 32'h3c);
    wt(200);
    rd(AI, 32'h7c);
    wb(1'h1, AI, 32'h04);
    rd(AI, 32'h78);
    press <= 1'h0;
    wt(30);
    rd(AI, 32'h7a);
    wb(1'h1, AI, 32'h7f);
    rd(AI, 32'h00);
    $display("hold test done");
    // Standby polarity table
    for (int i = 0; i < 4; i++)
    begin
      wb(1'h1, AC, 32'h1c | {26'h0, i[1], 5'h0});
      standby_i <= i[0];
      wt(6);
      chk(32'(stby), 32'(i[0] ^ i[1]));
    end
    standby_i <= 1'h0;
    $display("standby test done");
    // Long press turn-off
    wb(1'h1, AC, 32'h04);
    press <= 1'h1;
    wt(30);
    rd(AI, 32'h01);
    wt(62);
    rd(AS, 32'h2c);
    wt(28);
    rd(AS, 32'h3c);
    till(1'h0, 1'h0, 1200);
    rd(AS, 32'h38);
    till(1'h1, 1'h0, 100);
    wt(4);
    rd(AS, 32'h00);
    press <= 1'h0;
    wb(1'h1, AI, 32'h7f);
    wt(20);
    $display("turn-off test done");
    // Long press device reset
    otp_db <= 2'h3;
    otp_dly <= 2'h1;
    wb(1'h1, AC, 32'h05);
    press <= 1'h1;
    till(1'h0, 1'h1, 100);
    till(1'h1, 1'h0, 1500);
    rd(AS, 32'h40);
    press <= 1'h0;
    till(1'h1, 1'h1, 4000);
    chk(32'(cnt > 3730 && cnt < 3760), 32'h1);
    till(1'h0, 1'h1, 100);
    rd(AC, 32'h0e);
    $display("device reset test done");
    // Level-sensitive mode
    edge_sel <= 1'h0;
    otp_slot <= 8'h05;
    press <= 1'h1;
    rst_i <= 1'h1;
    wt(5);
    rst_i <= 1'h0;
    wt(40);
    rd(AS, 32'h00);
    press <= 1'h0;
    till(1'h0, 1'h1, 100);
    press <= 1'h1;
    till(1'h1, 1'h0, 1500);
    wt(4);
    rd(AS, 32'h00);
    $display("level mode test done");
    print_verdict();
  end

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial
  begin
    wt(20000);
    error_cnt++;
    print_verdict();
  end
endmodule
